//--- shared/cisd_pkg.sv
//----------------------------------------------------------------------
// Purpose: constants and types for the command interface slot decoder
// Assumes: 100 MHz pclk, 32-bit APB register access
// Notes:   register map and field positions below
//----------------------------------------------------------------------
// Functional notes
// - sample four inputs, interrupt host on change
// - input must persist 1 ms before reporting
// - relays follow host command data
// - test mode takes inputs from test switches
// - entering test mode reports all inputs off
// - test input on only after off-to-on
// - real inputs ignored during test mode
// - leds show active relays and inputs
// - slot address decoded from two switches
// - slot address from switches only
// - generation switch on selects older host
// - compare host slot request with local address
// - strobe high, selects low resets controllers
// - readable input register shows board type
// - board variant from type input level
// - type zero command, one signaling
// - signaling relays mirror command inputs, outputs
// - contact doubling: slot two/four drives relays
// - four modules give sixteen commands each way
package cisd_pkg;
   localparam int          CISD_CHANNELS   = 4;
   localparam int          CISD_DEB_NS     = 1000000;
   localparam int          CISD_CLK_NS     = 10;
   localparam int          CISD_DEB_CYC    = (CISD_DEB_NS + CISD_CLK_NS - 1) / CISD_CLK_NS;
   localparam int          CISD_DEB_W      = 17;
   // register byte offsets
   localparam logic [7:0]  CISD_REG_INPUT  = 8'h00;
   localparam logic [7:0]  CISD_REG_CMD    = 8'h04;
   localparam logic [7:0]  CISD_REG_CTRL   = 8'h08;
   localparam logic [7:0]  CISD_REG_STAT   = 8'h0c;
   // input register fields
   localparam int          CISD_IN_TYPE    = 4;
   localparam int          CISD_IN_CHG     = 8;
   // control register fields
   localparam int          CISD_CTL_TEST   = 0;
   localparam int          CISD_CTL_SUPPLY = 1;
   localparam int          CISD_CTL_DOUBLE = 2;
   localparam int          CISD_CTL_IRQCLR = 3;
   localparam logic [3:0]  CISD_CMD_RST    = 4'h0;
   localparam logic [3:0]  CISD_CTL_RST    = 4'h0;

   typedef enum logic [3:0]
   {
      CISD_SLOT_ONE   = 4'b0001,
      CISD_SLOT_TWO   = 4'b0010,
      CISD_SLOT_THREE = 4'b0100,
      CISD_SLOT_FOUR  = 4'b1000
   } cisd_slot_t;

   typedef struct packed
   {
      logic slot_strobe_n;
      logic slot_select_bit1_n;
      logic slot_select_bit0_n;
   } cisd_slotbus_t;

   typedef struct packed
   {
      logic slot_switch_low;
      logic slot_switch_high;
      logic host_generation_switch;
   } cisd_addrsw_t;
endpackage

//--- logic/cisd_top.sv
//----------------------------------------------------------------------
// Purpose: module controller and slot address decoder of a command module
// Assumes: all pin inputs synchronous to pclk
// Notes:   apb register port is live only while this slot is selected
//----------------------------------------------------------------------
`timescale 1ns/100ps
module cisd_top
   import cisd_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire cisd_slotbus_t            slot_bus,
   input  wire cisd_addrsw_t             addr_sw,
   input  wire logic [CISD_CHANNELS-1:0] binary_in,
   input  wire logic [CISD_CHANNELS-1:0] test_input_switch,
   input  wire logic                     board_type,
   output logic                          irq_req,
   output logic                          slot_selected,
   output logic                          module_reset,
   output logic                          older_host,
   output logic      [CISD_CHANNELS-1:0] relay_out,
   output logic                          relay_supply_enable,
   output logic      [CISD_CHANNELS-1:0] output_led,
   output logic      [CISD_CHANNELS-1:0] input_led,
   output logic                          test_led
);

   //-------------------------------------------------------------------
   // slot decode
   //-------------------------------------------------------------------
   cisd_slot_t                 local_slot;
   cisd_slot_t                 req_slot;
   logic                       req_valid;
   logic                       ctl_rst;

   always_comb
   begin
      // switch address only; insertion position plays no part
      case ({addr_sw.slot_switch_high, addr_sw.slot_switch_low})
         2'b00:   local_slot = CISD_SLOT_ONE;
         2'b01:   local_slot = CISD_SLOT_TWO;
         2'b10:   local_slot = CISD_SLOT_THREE;
         default: local_slot = CISD_SLOT_FOUR;
      endcase
   end

   always_comb
   begin
      req_valid = ~slot_bus.slot_strobe_n;
      case ({slot_bus.slot_select_bit1_n, slot_bus.slot_select_bit0_n})
         2'b01:   req_slot = CISD_SLOT_ONE;
         2'b10:   req_slot = CISD_SLOT_TWO;
         2'b11:   req_slot = CISD_SLOT_THREE;
         default: req_slot = CISD_SLOT_FOUR;
      endcase
   end

   // global reset code; same code with strobe low means slot four
   assign ctl_rst = slot_bus.slot_strobe_n & ~slot_bus.slot_select_bit1_n
                    & ~slot_bus.slot_select_bit0_n;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_selected <= 1'b0;
         module_reset  <= 1'b0;
         older_host    <= 1'b0;
      end
      else
      begin
         slot_selected <= req_valid && (req_slot == local_slot);
         module_reset  <= ctl_rst;
         older_host    <= addr_sw.host_generation_switch;
      end
   end

   //-------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------
   logic [CISD_CHANNELS-1:0]   cmd;
   logic [3:0]                 ctrl;
   logic [CISD_CHANNELS-1:0]   in_state;
   logic                       changed;
   logic                       access;
   logic                       wr;
   logic                       set_chg;
   logic                       test_mode;
   logic                       doubling;

   assign test_mode = ctrl[CISD_CTL_TEST];
   assign doubling  = ctrl[CISD_CTL_DOUBLE];
   // bus ignored unless this slot is addressed
   assign access    = psel & penable & slot_selected;
   // write lands only at the edge that sees pready high, never twice
   assign wr        = access & pready & pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd  <= CISD_CMD_RST;
         ctrl <= CISD_CTL_RST;
      end
      else if (module_reset)
      begin
         cmd  <= CISD_CMD_RST;
         ctrl <= CISD_CTL_RST;
      end
      else if (wr && paddr == CISD_REG_CMD)
      begin
         cmd <= pwdata[CISD_CHANNELS-1:0];
      end
      else if (wr && paddr == CISD_REG_CTRL)
      begin
         ctrl <= {1'b0, pwdata[CISD_CTL_DOUBLE:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // one wait state; answer only when the slot is ours
         pready  <= psel & penable & ~pready & slot_selected;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && penable && !pready && !pwrite && slot_selected)
         begin
            if (paddr == CISD_REG_INPUT)
            begin
               // type bit lets the host tell command from signaling board
               prdata[CISD_CHANNELS-1:0] <= in_state;
               prdata[CISD_IN_TYPE]      <= board_type;
               prdata[CISD_IN_CHG]       <= changed;
            end
            else if (paddr == CISD_REG_CMD)
               prdata[CISD_CHANNELS-1:0] <= cmd;
            else if (paddr == CISD_REG_CTRL)
               prdata[CISD_CTL_DOUBLE:0] <= ctrl[CISD_CTL_DOUBLE:0];
            else if (paddr == CISD_REG_STAT)
               prdata[3:0] <= local_slot;
            else
               pslverr <= 1'b1;
         end
         else if (psel && penable && !pready && slot_selected)
         begin
            pslverr <= !(paddr == CISD_REG_CMD || paddr == CISD_REG_CTRL);
         end
      end
   end

   //-------------------------------------------------------------------
   // input qualification
   //-------------------------------------------------------------------
   logic [CISD_CHANNELS-1:0]   raw;
   logic [CISD_CHANNELS-1:0]   sw_armed;
   logic                       test_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         test_q <= 1'b0;
      else
         test_q <= test_mode;
   end

   genvar g;
   generate
      for (g = 0; g < CISD_CHANNELS; g = g + 1)
      begin : g_chan
         logic [CISD_DEB_W-1:0] cnt;

         // switch must be seen off before an on counts
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               sw_armed[g] <= 1'b0;
            else if (!test_mode || (test_mode && !test_q))
               sw_armed[g] <= 1'b0;
            else if (!test_input_switch[g])
               sw_armed[g] <= 1'b1;
         end

         // real inputs muted in test mode
         assign raw[g] = test_mode ? (sw_armed[g] & test_input_switch[g])
                                   : binary_in[g];

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cnt         <= '0;
               in_state[g] <= 1'b0;
            end
            else if (test_mode && !test_q)
            begin
               cnt         <= '0;
               in_state[g] <= 1'b0;
            end
            else if (raw[g] == in_state[g])
               cnt <= '0;
            else if (cnt == CISD_DEB_W'(CISD_DEB_CYC - 1))
            begin
               cnt         <= '0;
               in_state[g] <= raw[g];
            end
            else
               cnt <= cnt + 1'b1;
         end
      end
   endgenerate

   // qualified change pending, raised as a level to the host
   logic [CISD_CHANNELS-1:0]   in_prev;
   assign set_chg = |(in_prev ^ in_state);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_prev <= '0;
         changed <= 1'b0;
      end
      else
      begin
         in_prev <= in_state;
         // set wins over a simultaneous clear
         if (set_chg)
            changed <= 1'b1;
         else if (wr && paddr == CISD_REG_CTRL && pwdata[CISD_CTL_IRQCLR])
            changed <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // outputs
   //-------------------------------------------------------------------
   logic                       drive_ok;
   // with contact doubling only slot two or four switches relays
   assign drive_ok = ~doubling | (local_slot == CISD_SLOT_TWO)
                     | (local_slot == CISD_SLOT_FOUR);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_req             <= 1'b0;
         relay_out           <= '0;
         relay_supply_enable <= 1'b0;
         output_led          <= '0;
         input_led           <= '0;
         test_led            <= 1'b0;
      end
      else
      begin
         irq_req             <= changed;
         // signaling boards relay the host's mirror of command states
         relay_out           <= drive_ok ? cmd : '0;
         relay_supply_enable <= ctrl[CISD_CTL_SUPPLY];
         output_led          <= drive_ok ? cmd : '0;
         input_led           <= in_state;
         test_led            <= test_mode;
      end
   end

endmodule

//--- sim/cisd_checker.sv
// Purpose: port assertions for cisd_top
// Assumes: one pclk domain, presetn async active low
// Notes:   bound to the design below the module
`timescale 1ns/100ps
module cisd_checker
   import cisd_pkg::*;
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire cisd_slotbus_t slot_bus,
   input wire cisd_addrsw_t  addr_sw,
   input wire logic [3:0]    binary_in,
   input wire logic          irq_req,
   input wire logic          slot_selected,
   input wire logic          module_reset,
   input wire logic          older_host,
   input wire logic [3:0]    relay_out,
   input wire logic [3:0]    output_led,
   input wire logic [3:0]    input_led,
   input wire logic          test_led
);
   logic [1:0] loc_idx;
   logic       want_sel;
   assign loc_idx  = {addr_sw.slot_switch_high, addr_sw.slot_switch_low};
   assign want_sel = !slot_bus.slot_strobe_n &&
      ({slot_bus.slot_select_bit1_n, slot_bus.slot_select_bit0_n} == loc_idx + 2'h1);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   reset_code_a: assert property (slot_bus == 3'h4 |=> module_reset)
      else $error("module reset missing");
   sel_match_a: assert property (want_sel |=> slot_selected)
      else $error("own slot not selected");
   sel_other_a: assert property (!want_sel |=> !slot_selected)
      else $error("foreign slot selected");
   host_gen_a: assert property (1'b1 |=>
      older_host == $past(addr_sw.host_generation_switch))
      else $error("host generation wrong");
   led_mirror_a: assert property (output_led == relay_out)
      else $error("output leds differ from relays");
   take_ans_a: assert property (psel && penable && slot_selected && !pready |=> pready)
      else $error("no answer to access");
   no_ready_a: assert property (!slot_selected |=> !pready && !pslverr)
      else $error("answer while unselected");
   test_off_a: assert property ($rose(test_led) |=> (input_led == 4'h0)[*8])
      else $error("input on at test entry");
   debounce_a: assert property ($changed(input_led) && !test_led && !$past(test_led)
      && !$past(test_led, 2) |-> $past(binary_in) == $past(binary_in, 8))
      else $error("input reported unqualified");
   irq_chg_a: assert property ($changed(input_led) && !test_led |-> ##[0:3] irq_req)
      else $error("no interrupt on change");
endmodule

bind cisd_top cisd_checker chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .slot_bus, .addr_sw, .binary_in, .irq_req, .slot_selected, .module_reset, .older_host,
   .relay_out, .output_led, .input_led, .test_led);

//--- sim/cisd_host_model.sv
// Purpose: host controller side of the slot strobe and select lines
// Assumes: requests change just after a pclk edge
// Notes:   idle code selects nothing and resets nothing
`timescale 1ns/100ps
module cisd_host_model
   import cisd_pkg::*;
#(
   parameter bit STANDALONE = 1'b1
)
(
   input  wire logic       req_reset,
   input  wire logic       req_valid,
   input  wire logic [1:0] req_slot,
   output cisd_slotbus_t   slot_bus
);
   // slots three and four exist only in a stand-alone unit
   logic use_ok;
   assign use_ok   = STANDALONE || !req_slot[1];
   assign slot_bus = req_reset ? 3'h4 : (req_valid && use_ok) ? {1'b0, req_slot + 2'h1}
                   : 3'h7;
endmodule

//--- sim/command_interface_slot_decoder_tb_top.sv
// Purpose: self-checking bench for cisd_top
// Assumes: 100 MHz pclk, host model drives the slot lines
// Notes:   a single 1 ms qualification window keeps the run short
`timescale 1ns/100ps
module command_interface_slot_decoder_tb_top
   import cisd_pkg::*;
;
   logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
   logic          pready, pslverr, irq_req, slot_selected, module_reset, older_host;
   logic          relay_supply_enable, test_led, ok, rd_err;
   logic [3:0]    relay_out, output_led, input_led;
   logic [3:0]    binary_in = 4'h0, test_input_switch = 4'h0;
   logic          board_type = 1'b0, req_reset = 1'b0, req_valid = 1'b0;
   logic [1:0]    req_slot = 2'h0;
   cisd_addrsw_t  addr_sw = 3'h0;
   cisd_slotbus_t slot_bus;
   int            errors = 0, samples_checked = 0;

   always #5 pclk = ~pclk;
   cisd_host_model host_u (.req_reset, .req_valid, .req_slot, .slot_bus);
   cisd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .slot_bus, .addr_sw, .binary_in, .test_input_switch, .board_type,
      .irq_req, .slot_selected, .module_reset, .older_host, .relay_out,
      .relay_supply_enable, .output_led, .input_led, .test_led);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   // gives up after 20 waits so a refused access cannot hang the run
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      ok = (pready === 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // two extra edges so outputs fed by a written register have settled
      repeat (2) @(posedge pclk);
   endtask

   task automatic host_req(input logic rst, input logic vld);
      req_reset <= rst;
      req_valid <= vld;
      repeat (2) @(posedge pclk);
   endtask

   task automatic decode_slots();
      for (int s = 0; s < 4; s++)
         for (int r = 0; r < 4; r++)
         begin
            addr_sw <= {s[0], s[1], s[0]};
            req_slot <= r[1:0];
            host_req(1'b0, 1'b1);
            chk("slot_selected", 32'(r == s), 32'(slot_selected));
            chk("older_host", 32'(s[0]), 32'(older_host));
         end
      host_req(1'b1, 1'b0);
      chk("module_reset", 32'h0000_0001, 32'(module_reset));
   endtask

   task automatic registers();
      addr_sw <= 3'h0;
      req_slot <= 2'h0;
      host_req(1'b0, 1'b1);
      apb(1'b1, CISD_REG_CMD, 32'h0000_000a);
      chk("relay_out", 32'h0000_000a, 32'(relay_out));
      chk("output_led", 32'h0000_000a, 32'(output_led));
      apb(1'b0, CISD_REG_CMD, 32'h0000_0000);
      chk("cmd_read", 32'h0000_000a, rd);
      apb(1'b0, CISD_REG_STAT, 32'h0000_0000);
      chk("stat", 32'(CISD_SLOT_ONE), 32'(rd[3:0]));
      for (int b = 0; b < 2; b++)
      begin
         board_type <= b[0];
         apb(1'b0, CISD_REG_INPUT, 32'h0000_0000);
         chk("board_type", 32'(b), 32'(rd[CISD_IN_TYPE]));
      end
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, i == 0 ? 8'h00 : i == 1 ? 8'h0c : 8'h10, 32'h0000_0001);
         chk("pslverr", 32'h0000_0001, 32'(rd_err));
      end
      apb(1'b1, CISD_REG_CTRL, 32'h0000_0006);
      chk("relay_doubling", 32'h0000_0000, 32'(relay_out));
      chk("supply", 32'h0000_0001, 32'(relay_supply_enable));
      host_req(1'b1, 1'b0);
      // reset code is registered, then clears ctrl, then the supply flop
      repeat (2) @(posedge pclk);
      chk("supply_reset", 32'h0000_0000, 32'(relay_supply_enable));
      apb(1'b0, CISD_REG_INPUT, 32'h0000_0000);
      chk("unselected", 32'h0000_0000, 32'(ok));
   endtask

   task automatic inputs_and_test();
      host_req(1'b0, 1'b1);
      binary_in <= 4'h5;
      repeat (99990) @(posedge pclk);
      chk("input_early", 32'h0000_0000, 32'(input_led));
      repeat (20) @(posedge pclk);
      chk("input_led", 32'h0000_0005, 32'(input_led));
      chk("irq_req", 32'h0000_0001, 32'(irq_req));
      apb(1'b0, CISD_REG_INPUT, 32'h0000_0000);
      chk("input_reg", 32'h0000_0105, {23'h0, rd[8:0]} & 32'h0000_010f);
      apb(1'b1, CISD_REG_CTRL, 32'h0000_0008);
      chk("irq_clear", 32'h0000_0000, 32'(irq_req));
      test_input_switch <= 4'hf;
      apb(1'b1, CISD_REG_CTRL, 32'h0000_0001);
      chk("test_led", 32'h0000_0001, 32'(test_led));
      binary_in <= 4'ha;
      repeat (300) @(posedge pclk);
      chk("test_inputs", 32'h0000_0000, 32'(input_led));
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #2_000_000;
      errors++;
      tally_and_finish();
   end

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      decode_slots();
      registers();
      inputs_and_test();
      tally_and_finish();
   end
endmodule
